// ---- src/ascp_defines.svh ----
// Constants for the serial command port: command fields, special bytes and counts
`ifndef ASCP_DEFINES_SVH
`define ASCP_DEFINES_SVH

`define ASCP_CAL_BIT7       7
`define ASCP_CAL_BIT6       6
`define ASCP_PTR_HI         5
`define ASCP_PTR_LO         3
`define ASCP_TYPE_HI        2
`define ASCP_TYPE_LO        0
`define ASCP_RESYNC_FIRST   8'hff
`define ASCP_RESYNC_FINAL   8'hfe
`define ASCP_NULL_BYTE      8'h00
`define ASCP_CAL_SELF_OFS   3'h1
`define ASCP_CAL_SELF_GAIN  3'h2
`define ASCP_CAL_SYS_OFS    3'h5
`define ASCP_CAL_SYS_GAIN   3'h6
`define ASCP_CONV_MASK      8'h87
`define ASCP_CONV_CODE      8'h80
`define ASCP_CONV_REPEAT    6
`define ASCP_REG_MASK       8'h07
`define ASCP_REG_WR_SETUP   8'h05
`define ASCP_REG_WR_CFG     8'h03
`define ASCP_DATA_BITS      32
`define ASCP_DATA_CNT_RST   6'h00
`define ASCP_BIT_CNT_RST    3'h0

`endif

// ---- src/ascp_pkg.sv ----
// Types shared by the serial command port modules
package ascp_pkg;

    // Port decoder states, one-hot
    typedef enum logic [3:0] {
        ASCP_ST_CMD    = 4'b0001,
        ASCP_ST_DATA   = 4'b0010,
        ASCP_ST_RESYNC = 4'b0100,
        ASCP_ST_IDLE   = 4'b1000
    } ascp_state_e;

    // Calibration kinds as decoded
    typedef enum logic [2:0] {
        ASCP_CAL_NONE      = 3'h0,
        ASCP_CAL_SELF_OFS  = 3'h1,
        ASCP_CAL_SELF_GAIN = 3'h2,
        ASCP_CAL_SYS_OFS   = 3'h5,
        ASCP_CAL_SYS_GAIN  = 3'h6
    } ascp_cal_e;

endpackage

// ---- src/ascp_buf2.sv ----
// Two-entry buffer with valid and ready on both sides
`timescale 1ns/100ps
`default_nettype none

module ascp_buf2
    import ascp_pkg::*;
#(
    parameter int WIDTH = 32
)
(
    // Clock and reset
    input  wire logic             clk_i,
    input  wire logic             resetn_i,
    input  wire logic             ce_i,
    // Fill side
    input  wire logic             in_valid_i,
    output logic                  in_ready_o,
    input  wire logic [WIDTH-1:0] in_data_i,
    // Drain side
    output logic                  out_valid_o,
    input  wire logic             out_ready_i,
    output logic [WIDTH-1:0]      out_data_o
);

    typedef struct packed {
        logic [1:0][WIDTH-1:0] mem;       // Entry 0 is always the head
        logic [1:0]            count;
        logic                  has_data;  // Registered copy of count != 0
        logic                  full;      // Registered copy of count == 2
    } ascp_buf_s;

    ascp_buf_s st_ff;
    ascp_buf_s nxt_st;
    logic      push;
    logic      pop;

    // Handshakes and next contents; the head never moves, so outputs come from flops
    always_comb
    begin
        nxt_st = st_ff;
        push   = in_valid_i && !st_ff.full;
        pop    = out_ready_i && st_ff.has_data;
        if (pop)
        begin
            nxt_st.mem[0] = st_ff.mem[1];
        end
        if (push)
        begin
            if ((st_ff.count == 2'h0) || pop)
            begin
                nxt_st.mem[0] = in_data_i;
            end
            else
            begin
                nxt_st.mem[1] = in_data_i;
            end
        end
        nxt_st.count    = st_ff.count + {1'b0, push} - {1'b0, pop};
        nxt_st.has_data = (nxt_st.count != 2'h0);
        nxt_st.full     = (nxt_st.count == 2'h2);
    end

    // State register
    always_ff @(posedge clk_i or negedge resetn_i)
    begin
        if (!resetn_i)
        begin
            st_ff <= '0;
        end
        else if (ce_i)
        begin
            st_ff <= nxt_st;
        end
    end

    assign in_ready_o  = !st_ff.full;      // Full refuses
    assign out_valid_o = st_ff.has_data;   // Empty shows nothing
    assign out_data_o  = st_ff.mem[0];

    chk_buf_stall_hold : assert property (@(posedge clk_i) disable iff (!resetn_i)
        ce_i && out_valid_o && !out_ready_i |=> out_valid_o && $stable(out_data_o))
        else $error("buffered word lost during a stall");

endmodule

`default_nettype wire

// ---- src/ascp_port.sv ----
// Serial command port: pin sampling, command decode, data shifting, buffered output
//
// How it works
// - Pointer 000..111 selects setup one to eight for the calibration.
// - Byte of all ones starts the port resynchronisation.
// - Byte 0xfe ends resynchronisation; port then expects a command.
// - Null byte clears the port flag, continuous conversion stays on.
// - Port accepts traffic only while chip select is low.
// - With chip select tied low the port still works on three wires.
// - Commands and write data enter bit by bit on serial input.
// - Read-back and conversion data leave on serial output.
// - Serial output is released whenever chip select is high.
// - Clock edges while deselected are ignored.
// - Bits shift only on serial clock transitions.
// - After a register command 32 data bits move, then command mode.
`timescale 1ns/100ps
`default_nettype none
`include "ascp_defines.svh"

module ascp_port
    import ascp_pkg::*;
#(
    parameter int DATA_BITS = `ASCP_DATA_BITS
)
(
    // Clock, reset, enable
    input  wire logic                 clk_i,
    input  wire logic                 resetn_i,
    input  wire logic                 ce_i,
    // Serial pins
    input  wire logic                 cs_n_i,
    input  wire logic                 sclk_i,
    input  wire logic                 sdi_i,
    output logic                      sdo_o,
    output logic                      sdo_oe_o,
    // Read-back word from the core
    input  wire logic [DATA_BITS-1:0] rd_data_i,
    // Conversion data from the core
    input  wire logic                 conv_valid_i,
    input  wire logic [DATA_BITS-1:0] conv_data_i,
    // Received register write data to the core
    output logic                      wr_valid_o,
    input  wire logic                 wr_ready_i,
    output logic [DATA_BITS-1:0]      wr_data_o,
    output logic [7:0]                wr_cmd_o,
    // Calibration request
    output logic                      cal_start_o,
    output logic [2:0]                setup_pointer_o,
    output logic [2:0]                calibration_type_o,
    // Conversion request and port flag
    output logic                      conv_start_o,
    output logic                      repeat_conversion_select_o,
    output logic                      port_flag_o,
    // Status
    output logic                      resync_active_o
);

    typedef struct packed {
        logic [1:0]           cs_sync;
        logic [1:0]           sclk_sync;
        logic [1:0]           sdi_sync;
        logic                 sclk_prev;
        ascp_state_e          state;
        logic [7:0]           shreg;
        logic [2:0]           bit_cnt;
        logic [5:0]           data_cnt;
        logic                 data_write;
        logic [7:0]           cmd;
        logic [DATA_BITS-1:0] word;
        logic                 push;
        logic                 sdo;
        logic                 sdo_oe;
        logic                 cal_start;
        logic [2:0]           setup_pointer;
        logic [2:0]           cal_type;
        logic                 conv_start;
        logic                 repeat_sel;
        logic                 port_flag;
        logic                 resync;
    } ascp_port_s;

    ascp_port_s st_ff;
    ascp_port_s nxt_st;
    logic       buf_in_ready;
    logic       buf_out_valid;
    logic [DATA_BITS-1:0] buf_out_data;

    // Calibration byte test, used by the decoder and the checks
    function automatic logic is_cal_cmd(input logic [7:0] b);
        logic [2:0] t;
        t = b[`ASCP_TYPE_HI:`ASCP_TYPE_LO];
        is_cal_cmd = b[`ASCP_CAL_BIT7] && !b[`ASCP_CAL_BIT6]
            && (t == `ASCP_CAL_SELF_OFS || t == `ASCP_CAL_SELF_GAIN
                || t == `ASCP_CAL_SYS_OFS || t == `ASCP_CAL_SYS_GAIN);
    endfunction

    // Register access bytes: bit7 clear, low field names a register
    function automatic logic is_reg_cmd(input logic [7:0] b);
        is_reg_cmd = !b[7] && (b != `ASCP_NULL_BYTE);
    endfunction

    logic       sclk_rise;
    logic       sclk_fall;
    logic       selected;
    logic [7:0] byte_in;

    // Edge finding on the synchronised clock, gated by chip select
    assign selected  = !st_ff.cs_sync[1];
    assign sclk_rise = selected && st_ff.sclk_sync[1] && !st_ff.sclk_prev;
    assign sclk_fall = selected && !st_ff.sclk_sync[1] && st_ff.sclk_prev;
    assign byte_in   = {st_ff.shreg[6:0], st_ff.sdi_sync[1]};

    // Decoder and shifter
    always_comb
    begin
        nxt_st            = st_ff;
        nxt_st.cs_sync    = {st_ff.cs_sync[0], cs_n_i};
        nxt_st.sclk_sync  = {st_ff.sclk_sync[0], sclk_i};
        nxt_st.sdi_sync   = {st_ff.sdi_sync[0], sdi_i};
        nxt_st.sclk_prev  = st_ff.sclk_sync[1];
        nxt_st.cal_start  = 1'b0;
        nxt_st.conv_start = 1'b0;
        nxt_st.push       = 1'b0;
        nxt_st.sdo_oe     = selected;
        if (!selected)
        begin
            nxt_st.sdo = 1'b0;
        end
        // Output data changes on the falling edge
        if (sclk_fall && st_ff.state == ASCP_ST_DATA && !st_ff.data_write)
        begin
            nxt_st.sdo  = st_ff.word[DATA_BITS-1];
            nxt_st.word = {st_ff.word[DATA_BITS-2:0], 1'b0};
        end
        // Input bits are taken on the rising edge
        if (sclk_rise)
        begin
            case (st_ff.state)
                ASCP_ST_CMD, ASCP_ST_RESYNC, ASCP_ST_IDLE:
                begin
                    nxt_st.shreg   = byte_in;
                    nxt_st.bit_cnt = st_ff.bit_cnt + 3'h1;
                    if (st_ff.bit_cnt == 3'h7)
                    begin
                        nxt_st.state = ASCP_ST_CMD;
                        if (byte_in == `ASCP_RESYNC_FIRST)
                        begin
                            nxt_st.state  = ASCP_ST_RESYNC;
                            nxt_st.resync = 1'b1;
                        end
                        else if (byte_in == `ASCP_RESYNC_FINAL)
                        begin
                            nxt_st.resync = 1'b0;
                        end
                        else if (st_ff.state == ASCP_ST_RESYNC)
                        begin
                            nxt_st.state = ASCP_ST_RESYNC;
                        end
                        else if (byte_in == `ASCP_NULL_BYTE)
                        begin
                            nxt_st.port_flag = 1'b0;
                        end
                        else if (is_cal_cmd(byte_in))
                        begin
                            nxt_st.cal_start     = 1'b1;
                            nxt_st.setup_pointer = byte_in[`ASCP_PTR_HI:`ASCP_PTR_LO];
                            nxt_st.cal_type      = byte_in[`ASCP_TYPE_HI:`ASCP_TYPE_LO];
                            nxt_st.repeat_sel    = 1'b0;
                        end
                        else if ((byte_in & `ASCP_CONV_MASK) == `ASCP_CONV_CODE)
                        begin
                            nxt_st.conv_start    = 1'b1;
                            nxt_st.setup_pointer = byte_in[`ASCP_PTR_HI:`ASCP_PTR_LO];
                            nxt_st.repeat_sel    = byte_in[`ASCP_CONV_REPEAT];
                            nxt_st.port_flag     = byte_in[`ASCP_CONV_REPEAT];
                        end
                        else if (is_reg_cmd(byte_in))
                        begin
                            nxt_st.state      = ASCP_ST_DATA;
                            nxt_st.cmd        = byte_in;
                            nxt_st.data_cnt   = `ASCP_DATA_CNT_RST;
                            nxt_st.data_write = !byte_in[3];
                            nxt_st.word       = rd_data_i;
                        end
                    end
                end
                ASCP_ST_DATA:
                begin
                    nxt_st.data_cnt = st_ff.data_cnt + 6'h1;
                    if (st_ff.data_write)
                    begin
                        nxt_st.word = {st_ff.word[DATA_BITS-2:0], st_ff.sdi_sync[1]};
                    end
                    if (st_ff.data_cnt == 6'(DATA_BITS - 1))
                    begin
                        nxt_st.state   = ASCP_ST_CMD;
                        nxt_st.bit_cnt = `ASCP_BIT_CNT_RST;
                        nxt_st.push    = st_ff.data_write;
                    end
                end
                default:
                begin
                    nxt_st.state = ASCP_ST_CMD;
                end
            endcase
        end
        // Conversion words ride out in continuous mode when the port is idle in command mode
        if (conv_valid_i && st_ff.state == ASCP_ST_CMD && st_ff.bit_cnt == 3'h0
            && st_ff.repeat_sel && !sclk_rise)
        begin
            nxt_st.word       = conv_data_i;
            nxt_st.state      = ASCP_ST_DATA;
            nxt_st.data_write = 1'b0;
            nxt_st.data_cnt   = `ASCP_DATA_CNT_RST;
        end
        // Receiver stall: hold a finished write until the buffer takes it
        if (st_ff.push && !buf_in_ready)
        begin
            nxt_st.push = 1'b1;
        end
    end

    // State register with clock enable
    always_ff @(posedge clk_i or negedge resetn_i)
    begin
        if (!resetn_i)
        begin
            st_ff           <= '0;
            st_ff.cs_sync   <= 2'b11;
            st_ff.sclk_sync <= 2'b00;
            st_ff.state     <= ASCP_ST_CMD;
        end
        else if (ce_i)
        begin
            st_ff <= nxt_st;
        end
    end

    // Write words pass a two-entry buffer toward the core
    ascp_buf2 #(
        .WIDTH (DATA_BITS)
    ) u_buf (
        .clk_i       (clk_i),
        .resetn_i    (resetn_i),
        .ce_i        (ce_i),
        .in_valid_i  (st_ff.push),
        .in_ready_o  (buf_in_ready),
        .in_data_i   (st_ff.word),
        .out_valid_o (buf_out_valid),
        .out_ready_i (wr_ready_i),
        .out_data_o  (buf_out_data)
    );

    // Outputs straight from flip-flops
    assign sdo_o                      = st_ff.sdo;
    assign sdo_oe_o                   = st_ff.sdo_oe;
    assign wr_valid_o                 = buf_out_valid;
    assign wr_data_o                  = buf_out_data;
    assign wr_cmd_o                   = st_ff.cmd;
    assign cal_start_o                = st_ff.cal_start;
    assign setup_pointer_o            = st_ff.setup_pointer;
    assign calibration_type_o         = st_ff.cal_type;
    assign conv_start_o               = st_ff.conv_start;
    assign repeat_conversion_select_o = st_ff.repeat_sel;
    assign port_flag_o                = st_ff.port_flag;
    assign resync_active_o            = st_ff.resync;

    // Checks
    chk_sdo_release : assert property (@(posedge clk_i) disable iff (!resetn_i)
        $past(ce_i) && $past(st_ff.cs_sync[1]) |-> !sdo_oe_o)
        else $error("serial output driven while deselected");

    chk_desel_no_shift : assert property (@(posedge clk_i) disable iff (!resetn_i)
        ce_i && st_ff.cs_sync[1] |=> $stable(st_ff.shreg))
        else $error("shift while deselected");

    chk_cal_fields : assert property (@(posedge clk_i) disable iff (!resetn_i)
        cal_start_o |-> is_cal_cmd({2'b10, setup_pointer_o, calibration_type_o}))
        else $error("calibration pulse with bad type");

    chk_cal_pointer : assert property (@(posedge clk_i) disable iff (!resetn_i)
        $past(ce_i) && cal_start_o |-> setup_pointer_o == $past(byte_in[5:3], 1))
        else $error("setup pointer mismatch");

    chk_resync_enter : assert property (@(posedge clk_i) disable iff (!resetn_i)
        ce_i && sclk_rise && st_ff.state != ASCP_ST_DATA && st_ff.bit_cnt == 3'h7
        && byte_in == `ASCP_RESYNC_FIRST |=> resync_active_o)
        else $error("resync not entered");

    chk_resync_exit : assert property (@(posedge clk_i) disable iff (!resetn_i)
        ce_i && sclk_rise && st_ff.state == ASCP_ST_RESYNC && st_ff.bit_cnt == 3'h7
        && byte_in == `ASCP_RESYNC_FINAL |=> !resync_active_o && st_ff.state == ASCP_ST_CMD)
        else $error("resync not left");

    chk_null_flag : assert property (@(posedge clk_i) disable iff (!resetn_i)
        ce_i && sclk_rise && st_ff.state == ASCP_ST_CMD && st_ff.bit_cnt == 3'h7
        && byte_in == `ASCP_NULL_BYTE |=> !port_flag_o && $stable(repeat_conversion_select_o))
        else $error("null byte handling wrong");

    chk_data_end : assert property (@(posedge clk_i) disable iff (!resetn_i)
        ce_i && sclk_rise && st_ff.state == ASCP_ST_DATA && st_ff.data_cnt == 6'(DATA_BITS - 1)
        |=> st_ff.state == ASCP_ST_CMD)
        else $error("port stuck after data word");

endmodule

`default_nettype wire

// ---- bench/ascp_host_model.sv ----
// Host bus master model: chip select, serial clock and data in, reads data out
`timescale 1ns/100ps
`default_nettype none

module ascp_host_model
(
    // Clock
    input  wire logic clk_i,
    // Serial pins
    output logic      cs_n_o,
    output logic      sclk_o,
    output logic      sdi_o,
    input  wire logic sdo_i
);
    localparam int HALF_CLKS = 8; // 160 ns serial period

    // Idle levels at time zero: deselected, clock low
    initial
    begin
        cs_n_o = 1'b1;
        sclk_o = 1'b0;
        sdi_o  = 1'b0;
    end

    // Wait a number of clock falls
    task automatic idle(input int n);
        repeat (n) @(negedge clk_i);
    endtask

    // Select first, so the synchronisers settle before the first edge
    task automatic open_frame();
        idle(1);
        cs_n_o = 1'b0;
        idle(6);
    endtask

    // Clock stands low, data line stops holding its last value
    task automatic close_frame();
        sclk_o = 1'b0;
        idle(6);
        cs_n_o = 1'b1;
        sdi_o  = ~sdi_o;
        idle(6);
    endtask

    // Data set while clock low, data out taken just before the rise
    task automatic xfer_bit(input logic b, output logic r);
        sclk_o = 1'b0;
        sdi_o  = b;
        idle(HALF_CLKS);
        r      = sdo_i;
        sclk_o = 1'b1;
        idle(HALF_CLKS);
    endtask

    // Command byte, most significant bit first
    task automatic send_byte(input logic [7:0] v);
        logic r;
        for (int i = 7; i >= 0; i--)
            xfer_bit(v[i], r);
    endtask

    // Data word after a register command
    task automatic xfer_word(input logic [31:0] w, output logic [31:0] r);
        for (int i = 31; i >= 0; i--)
            xfer_bit(w[i], r[i]);
    endtask
endmodule
`default_nettype wire

// ---- bench/adc_serial_command_port_tb.sv ----
// Self-checking testbench of the serial command port
`timescale 1ns/100ps
`default_nettype none
`include "ascp_defines.svh"

module adc_serial_command_port_tb;
    logic        clk_i;
    logic        resetn_i;
    logic        cs_n;
    logic        sclk;
    logic        sdi;
    logic        sdo_o;
    logic        sdo_oe_o;
    logic        sdo_w;
    logic        float_bit;
    logic [31:0] rd_data;
    logic        wr_valid_o;
    logic        wr_ready;
    logic [31:0] wr_data_o;
    logic [7:0]  wr_cmd_o;
    logic        cal_start_o;
    logic [2:0]  setup_pointer_o;
    logic [2:0]  calibration_type_o;
    logic        conv_start_o;
    logic        repeat_sel_o;
    logic        port_flag_o;
    logic        resync_active_o;
    int          bad_count;
    int          n_checks;
    int          n_cal;
    int          n_conv;
    logic        ce;
    logic        conv_valid;
    logic [31:0] conv_data;

    // Released data line shows a pattern that changes every cycle
    assign sdo_w = sdo_oe_o ? sdo_o : float_bit;

    ascp_port DUT (
        .clk_i(clk_i), .resetn_i(resetn_i), .ce_i(ce),
        .cs_n_i(cs_n), .sclk_i(sclk), .sdi_i(sdi), .sdo_o(sdo_o), .sdo_oe_o(sdo_oe_o),
        .rd_data_i(rd_data), .conv_valid_i(conv_valid), .conv_data_i(conv_data),
        .wr_valid_o(wr_valid_o), .wr_ready_i(wr_ready), .wr_data_o(wr_data_o),
        .wr_cmd_o(wr_cmd_o), .cal_start_o(cal_start_o), .setup_pointer_o(setup_pointer_o),
        .calibration_type_o(calibration_type_o), .conv_start_o(conv_start_o),
        .repeat_conversion_select_o(repeat_sel_o), .port_flag_o(port_flag_o),
        .resync_active_o(resync_active_o)
    );

    ascp_host_model HOST (.clk_i(clk_i), .cs_n_o(cs_n), .sclk_o(sclk), .sdi_o(sdi),
        .sdo_i(sdo_w));

    // Clock
    initial
    begin
        clk_i = 1'b0;
        forever #5 clk_i = ~clk_i;
    end

    // Pulse counters and floating pattern
    always @(posedge clk_i)
    begin
        float_bit <= (float_bit === 1'b1) ? 1'b0 : 1'b1;
        if (cal_start_o === 1'b1) n_cal <= n_cal + 1;
        if (conv_start_o === 1'b1) n_conv <= n_conv + 1;
    end

    task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
        n_checks++;
        if (seen !== exp)
        begin
            bad_count++;
            $display("[ERR] %s expected %h seen %h", what, exp, seen);
        end
    endtask

    task automatic tally_and_finish();
        $display("checks %0d errors %0d", n_checks, bad_count);
        if (bad_count == 0 && n_checks > 0)
            $display("STATUS OK");
        else
            $display("STATUS NOT OK");
        $finish;
    endtask

    // Bounded wait for a buffered write word
    task automatic wait_valid();
        for (int i = 0; i < 40; i++)
        begin
            if (wr_valid_o === 1'b1) return;
            @(negedge clk_i);
        end
        bad_count++;
        $display("[ERR] wr_valid_o expected 1 seen timeout");
        tally_and_finish();
    endtask

    // Calibration byte in a frame of its own
    task automatic cal_probe(input logic [2:0] p, input logic [2:0] t);
        int  c0;
        logic ok;
        c0 = n_cal;
        ok = (t == `ASCP_CAL_SELF_OFS) || (t == `ASCP_CAL_SELF_GAIN) ||
             (t == `ASCP_CAL_SYS_OFS) || (t == `ASCP_CAL_SYS_GAIN);
        HOST.open_frame();
        check("sdo_oe_o", sdo_oe_o, 1);
        HOST.send_byte({2'b10, p, t});
        HOST.close_frame();
        check("cal pulses", n_cal - c0, ok);
        if (ok)
        begin
            check("setup_pointer_o", setup_pointer_o, p);
            check("calibration_type_o", calibration_type_o, t);
        end
    endtask

    task automatic t_reset();
        check("sdo_oe_o", sdo_oe_o, 0);
        check("wr_valid_o", wr_valid_o, 0);
        check("port_flag_o", port_flag_o, 0);
        check("resync_active_o", resync_active_o, 0);
    endtask

    // Every type code, pointer from 111 down to 000
    task automatic t_cal();
        for (int t = 0; t < 8; t++)
            cal_probe(3'(7 - t), 3'(t));
    endtask

    // Chip select held low across the whole sequence
    task automatic t_resync();
        int c0;
        HOST.open_frame();
        HOST.send_byte(`ASCP_RESYNC_FIRST);
        check("resync_active_o", resync_active_o, 1);
        c0 = n_cal;
        HOST.send_byte(8'h89);
        check("cal pulses", n_cal - c0, 0);
        HOST.send_byte(`ASCP_RESYNC_FINAL);
        check("resync_active_o", resync_active_o, 0);
        HOST.send_byte(8'h92);
        check("cal pulses", n_cal - c0, 1);
        check("setup_pointer_o", setup_pointer_o, 2);
        HOST.close_frame();
    endtask

    task automatic t_conv();
        int          c0;
        logic [31:0] r;
        c0 = n_conv;
        HOST.open_frame();
        HOST.send_byte(8'hd8);
        check("conv pulses", n_conv - c0, 1);
        check("port_flag_o", port_flag_o, 1);
        HOST.send_byte(`ASCP_NULL_BYTE);
        check("port_flag_o", port_flag_o, 0);
        check("repeat_sel_o", repeat_sel_o, 1);
        check("conv pulses", n_conv - c0, 1);
        // A ready word rides out while continuous mode stays on
        conv_data  = 32'hc3a5_0f1e;
        conv_valid = 1'b1;
        HOST.idle(2);
        conv_valid = 1'b0;
        HOST.xfer_word(32'h0, r);
        check("conv word", r, 32'hc3a5_0f1e);
        HOST.close_frame();
    endtask

    // Three writes against a stalled core, then drained in order
    task automatic t_write();
        logic [31:0] w [3];
        logic [7:0]  c [3];
        logic [31:0] r;
        w = '{32'ha5c3_0f96, 32'h0000_0001, 32'h8000_0000};
        c = '{`ASCP_REG_WR_CFG, `ASCP_REG_WR_SETUP, 8'h15};
        for (int i = 0; i < 3; i++)
        begin
            HOST.open_frame();
            HOST.send_byte(c[i]);
            HOST.xfer_word(w[i], r);
            HOST.close_frame();
            wait_valid();
            check("wr_cmd_o", wr_cmd_o, c[i]);
        end
        for (int i = 0; i < 3; i++)
        begin
            wait_valid();
            check("wr_data_o", wr_data_o, w[i]);
            wr_ready = 1'b1;
            @(negedge clk_i);
            wr_ready = 1'b0;
            @(negedge clk_i);
        end
        HOST.idle(4);
        check("wr_valid_o", wr_valid_o, 0);
        cal_probe(3'h4, 3'h5);
    endtask

    task automatic t_read();
        logic [31:0] r;
        rd_data = 32'h1234_5678;
        HOST.open_frame();
        HOST.send_byte(8'h0b);
        HOST.xfer_word(32'h0, r);
        HOST.close_frame();
        check("read word", r, 32'h1234_5678);
        cal_probe(3'h0, 3'h6);
    endtask

    // Clock toggled while deselected must leave no trace
    task automatic t_desel();
        int c0;
        c0 = n_cal;
        HOST.send_byte(8'h91);
        check("cal pulses", n_cal - c0, 0);
        check("sdo_oe_o", sdo_oe_o, 0);
        HOST.close_frame();
        cal_probe(3'h3, 3'h2);
    endtask

    // Enable held low through a whole byte: the port must see none of it
    task automatic t_ce();
        int c0;
        c0 = n_cal;
        HOST.open_frame();
        ce = 1'b0;
        HOST.send_byte(8'h91);
        HOST.close_frame();
        ce = 1'b1;
        HOST.idle(4);
        check("cal pulses", n_cal - c0, 0);
        check("sdo_oe_o", sdo_oe_o, 0);
        cal_probe(3'h1, 3'h1);
    endtask

    initial
    begin
        resetn_i  = 1'b0;
        wr_ready  = 1'b0;
        rd_data   = 32'h0;
        ce        = 1'b1;
        conv_valid = 1'b0;
        conv_data = 32'h0;
        float_bit = 1'b0;
        bad_count = 0;
        n_checks  = 0;
        n_cal     = 0;
        n_conv    = 0;
        repeat (12) @(negedge clk_i);
        resetn_i = 1'b1;
        HOST.idle(4);
        t_reset();
        t_cal();
        t_resync();
        t_conv();
        t_write();
        t_read();
        t_desel();
        t_ce();
        tally_and_finish();
    end
endmodule
`default_nettype wire
